// *** wdr_pkg.sv ***
// Package of the watchdog reload and lock register block.
// Assumes a 10 MHz system clock and a 10 kHz watchdog tick derived from it.
`default_nettype none

package wdr_pkg;

  // Register indexes; byte address on the bus is four times the index
  localparam logic [11:0] IDX_KEY    = 12'hff0;
  localparam logic [11:0] IDX_UPPER  = 12'hff1;
  localparam logic [11:0] IDX_MIDDLE = 12'hff2;
  localparam logic [11:0] IDX_LOWER  = 12'hff3;

  // Unlock key bytes
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // Reload byte values after reset
  localparam logic [7:0] UPPER_RST  = 8'h00;
  localparam logic [7:0] MIDDLE_RST = 8'h04;
  localparam logic [7:0] LOWER_RST  = 8'h00;

  // Counter landmarks
  localparam logic [23:0] CNT_TIMEOUT    = 24'h000000;
  localparam logic [23:0] CNT_ONE        = 24'h000001;
  localparam logic [23:0] CNT_NO_REFRESH = 24'h000002;
  localparam logic [23:0] CNT_ROLLOVER   = 24'hffffff;
  localparam logic [23:0] RELOAD_MIN     = 24'h000004;

  // Watchdog tick timing
  localparam int RC_PERIOD_NS  = 100000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_CYCLES   = RC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = $clog2(TICK_CYCLES);

  // Lock sequencer states
  typedef enum logic [2:0] {
    LK_IDLE      = 3'b000,
    LK_KEY1      = 3'b001,
    LK_WR_UPPER  = 3'b010,
    LK_WR_MIDDLE = 3'b011,
    LK_WR_LOWER  = 3'b100
  } wdr_lock_e;

  // Stored 24-bit reload value as three bytes
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] middle;
    logic [7:0] lower;
  } wdr_reload_s;

  localparam wdr_reload_s RELOAD_RST = '{upper: UPPER_RST, middle: MIDDLE_RST,
                                         lower: LOWER_RST};

endpackage : wdr_pkg

`default_nettype wire

// *** wdr_watchdog_regs.sv ***
// Watchdog reload registers, unlock sequencer and 24-bit down-counter.
// Assumes an Avalon-MM master on the same clock, and CPU strobes on that clock.
`timescale 1ns/1ps
`default_nettype none

module wdr_watchdog_regs
  import wdr_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              nrst,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output var  logic [31:0]       avs_readdata,
  output var  logic              avs_waitrequest,
  // CPU side
  input  wire logic              refreshExec,
  input  wire logic              alwaysOnOption,
  input  wire logic [7:0]        resetStatus,
  // Watchdog state
  output var  logic              timeoutPulse,
  output var  logic              wdtRunning,
  output var  logic              reloadUnlocked
);

  if (ADDR_W < 14 || ADDR_W > 32) begin : gBadAddrW
    $error("ADDR_W must lie between 14 and 32");
  end

  // Word index of the request against a register index
  function automatic logic idxHit(input logic [ADDR_W-1:0] addr, input logic [11:0] idx);
    idxHit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction : idxHit

  logic        ackReg;
  logic [31:0] readData_reg;
  wdr_lock_e   lockState_reg;
  wdr_reload_s reload_reg;
  logic [23:0] count_reg;
  logic        running_reg;
  logic [TICK_W-1:0] tickCnt_reg;
  logic        timeout_reg;

  logic        hitKey;
  logic        hitUpper;
  logic        hitMiddle;
  logic        hitLower;
  logic        rdTake;
  logic        wrAccept;
  logic        laneOk;
  logic [7:0]  wrByte;
  logic        keyFirst;
  logic        keySecond;
  logic        tickNow;
  logic        startLoad;
  logic        refreshOk;

  assign hitKey    = idxHit(avs_address, IDX_KEY);
  assign hitUpper  = idxHit(avs_address, IDX_UPPER);
  assign hitMiddle = idxHit(avs_address, IDX_MIDDLE);
  assign hitLower  = idxHit(avs_address, IDX_LOWER);
  assign laneOk    = avs_byteenable[0];
  assign wrByte    = avs_writedata[7:0];

  // Two-cycle answer: wait on the first cycle, accept on the second
  assign avs_waitrequest = (avs_read | avs_write) & ~ackReg;
  assign rdTake          = avs_read & ~ackReg;
  assign wrAccept        = avs_write & ackReg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ackReg <= 1'b0;
    end else begin
      ackReg <= (avs_read | avs_write) & ~ackReg;
    end
  end

  // Read data captured one cycle ahead of the accepting edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      readData_reg <= 32'h00000000;
    end else if (rdTake) begin
      if (hitKey) begin
        readData_reg <= {24'h000000, resetStatus};
      end else if (hitUpper) begin
        readData_reg <= {24'h000000, count_reg[23:16]};
      end else if (hitMiddle) begin
        readData_reg <= {24'h000000, count_reg[15:8]};
      end else if (hitLower) begin
        readData_reg <= {24'h000000, count_reg[7:0]};
      end else begin
        readData_reg <= 32'h00000000;
      end
    end
  end

  assign avs_readdata = readData_reg;

  // Unlock sequencer; any accepted write out of order relocks
  assign keyFirst  = hitKey & laneOk & (wrByte == KEY_FIRST);
  assign keySecond = hitKey & laneOk & (wrByte == KEY_SECOND);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lockState_reg <= LK_IDLE;
    end else if (wrAccept) begin
      unique case (lockState_reg)
        LK_IDLE: begin
          lockState_reg <= keyFirst ? LK_KEY1 : LK_IDLE;
        end
        LK_KEY1: begin
          if (keySecond) begin
            lockState_reg <= LK_WR_UPPER;
          end else if (keyFirst) begin
            lockState_reg <= LK_KEY1;
          end else begin
            lockState_reg <= LK_IDLE;
          end
        end
        LK_WR_UPPER: begin
          lockState_reg <= hitUpper ? LK_WR_MIDDLE : LK_IDLE;
        end
        LK_WR_MIDDLE: begin
          lockState_reg <= hitMiddle ? LK_WR_LOWER : LK_IDLE;
        end
        LK_WR_LOWER: begin
          lockState_reg <= LK_IDLE;
        end
        default: begin
          lockState_reg <= LK_IDLE;
        end
      endcase
    end
  end

  assign reloadUnlocked = (lockState_reg == LK_WR_UPPER) ||
                          (lockState_reg == LK_WR_MIDDLE) ||
                          (lockState_reg == LK_WR_LOWER);

  // Reload bytes; written only at their turn in the sequence
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reload_reg <= RELOAD_RST;
    end else if (wrAccept && laneOk) begin
      if (hitUpper && lockState_reg == LK_WR_UPPER) begin
        reload_reg.upper <= wrByte;
      end else if (hitMiddle && lockState_reg == LK_WR_MIDDLE) begin
        reload_reg.middle <= wrByte;
      end else if (hitLower && lockState_reg == LK_WR_LOWER) begin
        reload_reg.lower <= wrByte;
      end
    end
  end

  // Watchdog tick at the oscillator rate
  assign tickNow = (tickCnt_reg == TICK_W'(TICK_CYCLES - 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tickCnt_reg <= '0;
    end else if (tickNow) begin
      tickCnt_reg <= '0;
    end else begin
      tickCnt_reg <= tickCnt_reg + TICK_W'(1);
    end
  end

  // Enable stays on until system reset
  assign startLoad = ~running_reg & (refreshExec | alwaysOnOption);
  assign refreshOk = running_reg & refreshExec & (count_reg > CNT_NO_REFRESH);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      running_reg <= 1'b0;
    end else if (startLoad) begin
      running_reg <= 1'b1;
    end
  end

  assign wdtRunning = running_reg;

  // Down-counter; refusal near zero relies on a reload of at least four
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_reg <= RELOAD_RST;
    end else if (startLoad || refreshOk) begin
      count_reg <= reload_reg;
    end else if (running_reg && tickNow) begin
      if (count_reg == CNT_TIMEOUT) begin
        count_reg <= CNT_ROLLOVER;
      end else begin
        count_reg <= count_reg - CNT_ONE;
      end
    end
  end

  // Time-out when the count arrives at zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= running_reg & tickNow & ~refreshOk & ~startLoad &
                     (count_reg == CNT_ONE);
    end
  end

  assign timeoutPulse = timeout_reg;

  // Bus answer timing
  a_wait_one_cycle: assert property (
    @(posedge clock) disable iff (!nrst)
    ((avs_read || avs_write) && !ackReg) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("waitrequest did not drop after one cycle");

  a_key_reads_status: assert property (
    @(posedge clock) disable iff (!nrst)
    (rdTake && hitKey) |=> (avs_readdata == {24'h000000, $past(resetStatus)}))
    else $error("key address read did not return reset status");

  a_key_no_state: assert property (
    @(posedge clock) disable iff (!nrst)
    (wrAccept && hitKey) |=> (reload_reg == $past(reload_reg)))
    else $error("key write altered reload bytes");

  a_unlock_pair: assert property (
    @(posedge clock) disable iff (!nrst)
    (wrAccept && lockState_reg == LK_KEY1 && keySecond) |=> reloadUnlocked)
    else $error("key pair did not unlock");

  a_locked_ignore: assert property (
    @(posedge clock) disable iff (!nrst)
    (wrAccept && hitUpper && lockState_reg != LK_WR_UPPER)
    |=> (reload_reg.upper == $past(reload_reg.upper)))
    else $error("locked upper byte changed");

  a_seq_break: assert property (
    @(posedge clock) disable iff (!nrst)
    (wrAccept && lockState_reg == LK_WR_MIDDLE && !hitMiddle)
    |=> (lockState_reg == LK_IDLE && !reloadUnlocked))
    else $error("out-of-order write did not relock");

  a_relock_after: assert property (
    @(posedge clock) disable iff (!nrst)
    (wrAccept && laneOk && hitLower && lockState_reg == LK_WR_LOWER)
    |=> (lockState_reg == LK_IDLE && reload_reg.lower == $past(wrByte)))
    else $error("lower byte write did not store and relock");

  a_read_count: assert property (
    @(posedge clock) disable iff (!nrst)
    (rdTake && hitMiddle) |=> (avs_readdata[15:0] == {8'h00, $past(count_reg[15:8])}))
    else $error("middle read did not return live count");

  a_write_no_count: assert property (
    @(posedge clock) disable iff (!nrst)
    (wrAccept && hitUpper && !startLoad && !refreshOk && !(running_reg && tickNow))
    |=> (count_reg == $past(count_reg)))
    else $error("reload write disturbed running count");

  a_refresh_load: assert property (
    @(posedge clock) disable iff (!nrst)
    (startLoad || refreshOk) |=> (count_reg == $past(reload_reg)))
    else $error("enable or refresh did not load reload value");

  a_refresh_refused: assert property (
    @(posedge clock) disable iff (!nrst)
    (running_reg && refreshExec && count_reg <= CNT_NO_REFRESH && !tickNow)
    |=> (count_reg == $past(count_reg)))
    else $error("refresh accepted at or below two");

  a_timeout_zero: assert property (
    @(posedge clock) disable iff (!nrst)
    timeoutPulse |-> (count_reg == CNT_TIMEOUT) ##1 !timeoutPulse)
    else $error("time-out without zero count");

  a_always_on_start: assert property (
    @(posedge clock) disable iff (!nrst)
    (alwaysOnOption && !running_reg) |=> (running_reg && count_reg == $past(reload_reg)))
    else $error("always-on option did not start and load");

  a_running_sticky: assert property (
    @(posedge clock) disable iff (!nrst)
    running_reg |=> running_reg)
    else $error("watchdog stopped without reset");

  a_read_upper: assert property (
    @(posedge clock) disable iff (!nrst)
    (rdTake && hitUpper) |=> (avs_readdata == {24'h000000, $past(count_reg[23:16])}))
    else $error("upper read did not return live count");

  a_read_lower: assert property (
    @(posedge clock) disable iff (!nrst)
    (rdTake && hitLower) |=> (avs_readdata == {24'h000000, $past(count_reg[7:0])}))
    else $error("lower read did not return live count");

  a_upper_relock: assert property (
    @(posedge clock) disable iff (!nrst)
    (wrAccept && lockState_reg == LK_WR_UPPER && !hitUpper) |=> (lockState_reg == LK_IDLE))
    else $error("write other than upper did not relock");

  a_locked_middle: assert property (
    @(posedge clock) disable iff (!nrst)
    (wrAccept && hitMiddle && lockState_reg != LK_WR_MIDDLE)
    |=> (reload_reg.middle == $past(reload_reg.middle)))
    else $error("locked middle byte changed");

  a_locked_lower: assert property (
    @(posedge clock) disable iff (!nrst)
    (wrAccept && hitLower && lockState_reg != LK_WR_LOWER)
    |=> (reload_reg.lower == $past(reload_reg.lower)))
    else $error("locked lower byte changed");

  a_count_rollover: assert property (
    @(posedge clock) disable iff (!nrst)
    (running_reg && tickNow && !startLoad && !refreshOk && count_reg == CNT_TIMEOUT)
    |=> (count_reg == CNT_ROLLOVER))
    else $error("count did not roll over after time-out");

endmodule : wdr_watchdog_regs

`default_nettype wire

// *** test_watchdog_reload_lock_registers.sv ***
// Self-checking bench of the watchdog reload and lock registers.
// Assumes bus waits follow waitrequest and a count tick every 1000 clocks.
`timescale 1ns/1ps
`default_nettype none

module test_watchdog_reload_lock_registers
  import wdr_pkg::*;
;
  localparam logic [15:0] A_KEY = {2'b00, IDX_KEY, 2'b00};
  localparam logic [15:0] A_UP  = {2'b00, IDX_UPPER, 2'b00};
  localparam logic [15:0] A_MID = {2'b00, IDX_MIDDLE, 2'b00};
  localparam logic [15:0] A_LOW = {2'b00, IDX_LOWER, 2'b00};

  logic        clock, nrst, rd, wr, waitReq, refreshExec, alwaysOn;
  logic        timeoutPulse, wdtRunning, reloadUnlocked;
  logic [15:0] address;
  logic [31:0] wdata, rdata;
  logic [3:0]  byteEn;
  logic [7:0]  rstStatus, dummy;
  logic [23:0] lfsr, rel, rel2;
  logic [31:0] expQ[$], maskQ[$];
  string       nameQ[$];
  int          failures, n_compared, n;

  wdr_watchdog_regs dut (
    .clock(clock), .nrst(nrst), .avs_address(address), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(byteEn), .avs_readdata(rdata),
    .avs_waitrequest(waitReq), .refreshExec(refreshExec), .alwaysOnOption(alwaysOn),
    .resetStatus(rstStatus), .timeoutPulse(timeoutPulse), .wdtRunning(wdtRunning),
    .reloadUnlocked(reloadUnlocked));

  function automatic logic [23:0] lfsr_next(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction : lfsr_next

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic conclude();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // One Avalon access; reads leave a note for the monitor
  task automatic bus(input logic isRd, input logic [15:0] a, input logic [7:0] d,
                     input logic [7:0] e, input logic [7:0] m, input string nm,
                     output logic [7:0] q);
    if (isRd) begin
      expQ.push_back({24'h0, e});
      maskQ.push_back({24'hffffff, m});
      nameQ.push_back(nm);
    end
    rd      <= isRd;
    wr      <= !isRd;
    address <= a;
    wdata   <= {24'h0, d};
    do begin
      @(posedge clock);
    end while (waitReq !== 1'b0);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clock);
  endtask : bus

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    bus(1'b0, a, d, 8'h0, 8'h0, "", dummy);
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e, input string nm);
    bus(1'b1, a, 8'h0, e, 8'hff, nm, dummy);
  endtask : rd_reg

  task automatic rd_count(input logic [23:0] v);
    rd_reg(A_UP, v[23:16], "count upper");
    rd_reg(A_MID, v[15:8], "count middle");
    rd_reg(A_LOW, v[7:0], "count lower");
  endtask : rd_count

  task automatic program_reload(input logic [23:0] v);
    wr_reg(A_KEY, KEY_FIRST);
    wr_reg(A_KEY, KEY_SECOND);
    wr_reg(A_UP, v[23:16]);
    wr_reg(A_MID, v[15:8]);
    check("unlocked mid", 1, reloadUnlocked);
    wr_reg(A_LOW, v[7:0]);
  endtask : program_reload

  task automatic refresh();
    refreshExec <= 1'b1;
    @(posedge clock);
    refreshExec <= 1'b0;
    @(posedge clock);
  endtask : refresh

  // Waits until the count has just stepped
  task automatic sync_tick();
    logic [7:0] prev, now;
    int k;
    bus(1'b1, A_LOW, 8'h0, 8'h0, 8'h0, "poll", prev);
    k = 0;
    do begin
      bus(1'b1, A_LOW, 8'h0, 8'h0, 8'h0, "poll", now);
      k++;
    end while (now === prev && k < 700);
    check("tick seen", 1, k < 700);
  endtask : sync_tick

  always @(posedge clock) begin
    if (rd && waitReq === 1'b0 && expQ.size() > 0) begin
      check(nameQ.pop_front(), expQ.pop_front(), rdata & maskQ.pop_front());
    end
  end

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    repeat (40000) @(posedge clock);
    failures++;
    conclude();
  end

  initial begin
    {rd, wr, refreshExec, alwaysOn} = 4'h0;
    address = 16'h0;
    wdata = 32'h0;
    byteEn = 4'h1;
    nrst = 1'b0;
    failures = 0;
    n_compared = 0;
    lfsr = 24'h00005b;
    rstStatus = 8'h0;
    repeat (16) @(posedge clock);
    lfsr = lfsr_next(lfsr);
    nrst <= 1'b1;
    rstStatus <= lfsr[7:0];
    @(posedge clock);
    rd_reg(A_KEY, lfsr[7:0], "status");
    rd_count(24'h000400);
    rd_reg(16'h3fd0, 8'h00, "unmapped");
    wr_reg(A_KEY, KEY_SECOND);
    wr_reg(A_KEY, KEY_FIRST);
    rd_reg(A_KEY, lfsr[7:0], "status after key");
    check("unlock wrong order", 0, reloadUnlocked);
    wr_reg(A_KEY, KEY_FIRST);
    wr_reg(A_KEY, KEY_SECOND);
    check("unlock", 1, reloadUnlocked);
    wr_reg(16'h3fd0, 8'h11);
    check("relock other write", 0, reloadUnlocked);
    wr_reg(A_UP, 8'h77);
    wr_reg(A_LOW, 8'h77);
    lfsr = lfsr_next(lfsr);
    rel = (lfsr < 24'h4) ? 24'h4 : lfsr;
    program_reload(rel);
    check("relock after lower", 0, reloadUnlocked);
    wr_reg(A_KEY, KEY_FIRST);
    wr_reg(A_KEY, KEY_SECOND);
    wr_reg(A_UP, ~rel[23:16]);
    wr_reg(A_KEY, KEY_FIRST);
    wr_reg(A_MID, ~rel[15:8]);
    rel[23:16] = ~rel[23:16];
    rd_count(24'h000400);
    check("idle", 0, wdtRunning);
    refresh();
    check("running", 1, wdtRunning);
    sync_tick();
    refresh();
    rd_count(rel);
    lfsr = lfsr_next(lfsr);
    rel2 = (lfsr < 24'h4) ? 24'h4 : lfsr;
    program_reload(rel2);
    rd_count(rel);
    repeat (1000) @(posedge clock);
    rd_count(rel - 24'h1);
    refresh();
    rd_count(rel2);
    program_reload(RELOAD_MIN);
    sync_tick();
    refresh();
    repeat (2050) @(posedge clock);
    refresh();
    n = 0;
    while (timeoutPulse !== 1'b1 && n < 2500) begin
      @(posedge clock);
      n++;
    end
    check("timeout in time", 1, n < 2500);
    @(posedge clock);
    check("timeout one cycle", 0, timeoutPulse);
    repeat (1010) @(posedge clock);
    rd_reg(A_UP, 8'hff, "rollover");
    // Mid-run reset with the always-on option set
    nrst     <= 1'b0;
    alwaysOn <= 1'b1;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    @(posedge clock);
    check("always-on start", 1, wdtRunning);
    check("locked after reset", 0, reloadUnlocked);
    rd_count(24'h000400);
    conclude();
  end
endmodule : test_watchdog_reload_lock_registers

`default_nettype wire
